/* File: rtl/wsit_consts.vh */
// Contract
// - First byte: 7-bit address plus direction bit
// - Direction 0 writes, 1 reads
// - Matching address acked low on ninth clock
// - Mismatch: stay idle until next start
// - Write: eight bits then device acks
// - Data changes only while clock low
// - Read: device shifts out wiper setting
// - Each written byte loads new setting
// - Repeated reads return setting each byte
// - Target address is build-time parameter
// - Setting is 7-bit, 0 to 127
// - Reset presets setting to midscale
// - MSB ignored on write, zero on read
`ifndef WSIT_CONSTS_VH
`define WSIT_CONSTS_VH
`define WSIT_ADDR_W     7
`define WSIT_CODE_W     7
`define WSIT_ADDR_DEF   7'h2E
`define WSIT_MIDSCALE   7'h40
`define WSIT_BIT_LAST   4'h7
`define WSIT_BIT_ACK    4'h8
`define WSIT_BIT_ZERO   4'h0
`define WSIT_ST_IDLE    3'h0
`define WSIT_ST_ADDR    3'h1
`define WSIT_ST_WDATA   3'h2
`define WSIT_ST_RDATA   3'h3
`define WSIT_ST_RACK    3'h4
`endif

/* File: rtl/wsit_sync.v */
`timescale 1ns/100ps
`include "wsit_consts.vh"
// two-stage synchroniser for both bus lines plus edge history
module wsit_sync (
  // clock and reset
  input  wire mclk,
  input  wire rst,
  // raw bus levels
  input  wire scl_in,
  input  wire sda_in,
  // synchronised levels and previous samples
  output reg  scl_s,
  output reg  sda_s,
  output reg  scl_p,
  output reg  sda_p
);
  reg scl_m; // first stage, read only by second stage
  reg sda_m; // first stage, read only by second stage

  // idle bus is high, so reset to high avoids a false start
  always @(posedge mclk) begin
    if (rst) begin
      scl_m <= 1'b1;
      sda_m <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_in;
      sda_m <= sda_in;
      scl_s <= scl_m;
      sda_s <= sda_m;
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end
endmodule

/* File: rtl/wsit_target.v */
`timescale 1ns/100ps
`include "wsit_consts.vh"
// two-wire target holding the 7-bit wiper setting
module wsit_target #(
  parameter [6:0] TARGET_ADDR = `WSIT_ADDR_DEF // build-time address
) (
  // clock and reset
  input  wire       mclk,
  input  wire       rst,
  // bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // wiper setting to the resistor ladder
  output reg  [6:0] wiper_setting_register,
  output reg        wiper_update
);
  wire scl_s;   // synchronised clock line
  wire sda_s;   // synchronised data line
  wire scl_p;   // clock line one cycle earlier
  wire sda_p;   // data line one cycle earlier

  wsit_sync u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .scl_s  (scl_s),
    .sda_s  (sda_s),
    .scl_p  (scl_p),
    .sda_p  (sda_p)
  );

  // bus events, all from synchronised samples
  wire scl_rise = scl_s & ~scl_p;                 // sample point
  wire scl_fall = ~scl_s & scl_p;                 // drive change point
  wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_ev  = scl_s & scl_p & ~sda_p & sda_s;

  reg [2:0] st_q;      // protocol state
  reg [3:0] bit_q;     // bit index within nine-clock slot
  reg [7:0] sh_q;      // receive shift register
  reg [7:0] tx_q;      // transmit shift register
  reg       ack_q;     // device drives ack in this slot
  reg       nack_q;    // controller answered not-acknowledge

  // main protocol engine; scl edges seen by mclk, 400 ns bus period
  always @(posedge mclk) begin
    if (rst) begin
      st_q    <= `WSIT_ST_IDLE;
      bit_q   <= `WSIT_BIT_ZERO;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      wiper_setting_register <= `WSIT_MIDSCALE;
      wiper_update <= 1'b0;
    end else begin
      wiper_update <= 1'b0;
      sda_out      <= 1'b0; // open drain: only ever pulls low
      if (start_ev) begin
        // start (also repeated) abandons all and expects an address
        st_q   <= `WSIT_ST_ADDR;
        bit_q  <= `WSIT_BIT_ZERO;
        ack_q  <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        st_q   <= `WSIT_ST_IDLE;
        bit_q  <= `WSIT_BIT_ZERO;
        ack_q  <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        // sample on rising edge: line stable while clock high
        if (bit_q == `WSIT_BIT_ACK) begin
          bit_q <= `WSIT_BIT_ZERO;
          if (st_q == `WSIT_ST_RACK || st_q == `WSIT_ST_RDATA) begin
            nack_q <= sda_s; // high means controller is done
          end
        end else begin
          bit_q <= bit_q + 4'h1;
          sh_q  <= {sh_q[6:0], sda_s};
        end
      end else if (scl_fall) begin
        // drive changes only after the falling edge
        case (st_q)
          `WSIT_ST_IDLE: begin
            // idle: never drives
            sda_oe <= 1'b0;
          end
          `WSIT_ST_ADDR: begin
            if (bit_q == `WSIT_BIT_ACK && !ack_q) begin
              if (sh_q[7:1] == TARGET_ADDR) begin
                ack_q  <= 1'b1;
                sda_oe <= 1'b1; // low through ninth clock
              end else begin
                st_q   <= `WSIT_ST_IDLE;
                sda_oe <= 1'b0;
              end
            end else if (ack_q) begin
              ack_q <= 1'b0;
              if (sh_q[0]) begin
                // read mode, msb returns zero
                st_q   <= `WSIT_ST_RDATA;
                tx_q   <= {1'b0, wiper_setting_register} << 1;
                sda_oe <= 1'b1; // msb zero: pull low
              end else begin
                st_q   <= `WSIT_ST_WDATA;
                sda_oe <= 1'b0;
              end
            end else begin
              sda_oe <= 1'b0;
            end
          end
          `WSIT_ST_WDATA: begin
            if (bit_q == `WSIT_BIT_ACK && !ack_q) begin
              // full byte in: load at ack, msb dropped
              ack_q  <= 1'b1;
              sda_oe <= 1'b1;
              wiper_setting_register <= sh_q[6:0];
              wiper_update <= 1'b1;
            end else begin
              // stays in write state for next byte
              ack_q  <= 1'b0;
              sda_oe <= 1'b0;
            end
          end
          `WSIT_ST_RDATA: begin
            if (bit_q == `WSIT_BIT_ACK) begin
              // release for controller ack slot
              st_q   <= `WSIT_ST_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~tx_q[7];
              tx_q   <= {tx_q[6:0], 1'b0};
            end
          end
          `WSIT_ST_RACK: begin
            if (nack_q) begin
              st_q   <= `WSIT_ST_IDLE; // wait for stop
              sda_oe <= 1'b0;
            end else begin
              // acked: send setting again
              st_q   <= `WSIT_ST_RDATA;
              tx_q   <= {1'b0, wiper_setting_register} << 1;
              sda_oe <= 1'b1;
            end
          end
          default: begin
            st_q   <= `WSIT_ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

/* File: bench/wsit_target_props.sv */
`timescale 1ns/100ps
// pin checks in the mclk domain
module wsit_target_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [6:0] wiper_setting_register,
  input wire logic       wiper_update
);
  wire [6:0] w = wiper_setting_register;
  wire       u = wiper_update;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reset_mid_a: assert property ($fell(rst) |-> w == 7'h40 && !sda_oe)
    else $error("reset value");
  drain_low_a: assert property (!sda_out)
    else $error("sda_out high");
  upd_pulse_a: assert property (u |=> !u)
    else $error("long update");
  upd_low_a: assert property (u |-> !scl_in)
    else $error("update in high");
  upd_ack_a: assert property (u |-> ##[0:2] sda_oe)
    else $error("no ack on load");
  wiper_hold_a: assert property ($changed(w) |-> u || $past(u))
    else $error("stray load");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved in high");
  ack_len_a: assert property ($rose(sda_oe) |=> sda_oe [*6])
    else $error("short drive");
endmodule

bind wsit_target wsit_target_props i_props (.mclk, .rst, .scl_in, .sda_out, .sda_oe,
  .wiper_setting_register, .wiper_update);

/* File: bench/wsit_ctrl.sv */
`timescale 1ns/100ps
// bus controller; scl rests high between frames, sd high means released
module wsit_ctrl (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl = 1'b1,
  output logic      sd = 1'b1
);
  // one clock: data moves in the low phase, sampled late in the high phase
  task automatic bio(input logic o, output logic i);
    scl <= 1'b0;
    repeat (3) @(posedge mclk);
    sd <= o;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (2) @(posedge mclk);
    i = sda;
    @(posedge mclk);
  endtask
  task automatic xfer(input logic [7:0] o, input logic ao, output logic [7:0] r, output logic a);
    for (int k = 7; k >= 0; k--) bio(o[k], r[k]);
    bio(ao, a);
  endtask
  task automatic start;
    logic x;
    bio(1'b1, x);
    sd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic stop;
    logic x;
    bio(1'b0, x);
    sd <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule

/* File: bench/wsit_target_test.sv */
`timescale 1ns/100ps
// m is the reference wiper setting
module wsit_target_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        sda_out, sda_oe, wup, a;
  logic [6:0]  wp, m = 7'h40;
  logic [7:0]  r;
  logic [31:0] rs = 32'h626C;
  int          failures = 0, n_tests = 0;
  wire         scl, sd;
  wire         sda = sd & ~(sda_oe & ~sda_out); // pulled-up wire
  always #25 mclk = ~mclk;
  wsit_ctrl i_ctl (.mclk, .sda, .scl, .sd);
  wsit_target i_dut (.mclk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .wiper_setting_register(wp), .wiper_update(wup));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(input string n, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task adr(input logic [7:0] b);
    i_ctl.start();
    i_ctl.xfer(b, 1'b1, r, a);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("wiper", {1'b0, m}, {1'b0, wp});
    // write, repeated start read, stop, twice
    for (int k = 0; k < 4; k++) begin
      adr({7'h2E, k[0]});
      chk("ack", 8'h0, {7'h0, a});
      for (int j = 0; j < 2; j++) begin
        rs = xs(rs);
        i_ctl.xfer(k[0] ? 8'hFF : rs[7:0], !k[0] || j == 1, r, a);
        if (k[0]) chk("read", {1'b0, m}, r);
        else begin
          m = rs[6:0];
          chk("ack", 8'h0, {7'h0, a});
          chk("wiper", {1'b0, m}, {1'b0, wp});
        end
      end
      if (k[0]) i_ctl.stop();
    end
    adr({7'h2F, 1'b0});
    chk("nak", 8'h1, {7'h0, a});
    i_ctl.xfer(8'h11, 1'b1, r, a);
    chk("nak", 8'h1, {7'h0, a});
    adr({7'h2E, 1'b0});
    repeat (4) i_ctl.bio(1'b0, a);
    i_ctl.stop();
    chk("wiper", {1'b0, m}, {1'b0, wp});
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("wiper", 8'h40, {1'b0, wp});
    test_done;
  end
  // watchdog, run needs about 62 us
  initial begin
    #1000000;
    failures++;
    test_done;
  end
endmodule
